// *** eee_capability_wake_error.sv ***
// EEE per-port capability status, local advertisement and wake-up error counter.
//
// Operation
// (R1) Bit 14: partner 10GBASE-KR EEE, read-only.
// (R2) Bit 13: partner 10GBASE-KX4 EEE, read-only.
// (R3) Bit 12: partner 1000BASE-KX EEE, read-only.
// (R4) Bit 11: partner 10GBASE-T EEE, read-only.
// (R5) Bit 10: partner 1000BASE-T EEE, read-only.
// (R6) Bit 9: partner 100BASE-TX EEE; flags reset zero.
// (R7) Bit 1: local 100BASE-TX advertise, writable, resets one.
// (R8) Count wakes longer than threshold, sixteen bits.
// (R9) Threshold is global, defaults to 20.5 us.
// (R10) Reading counter returns value, then clears it.
// (R11) Select EEE space and port via 0x6E.
// (R12) Offset in 0x6F, data through 0xA0.
// (R13) Counter high byte 0x2A, low 0x2B.
// (R14) Next-page exchange fills partner flags when enabled.
// (R15) Reserved capability bits read zero, ignore writes.
// (R16) Counter saturates at maximum, never wraps.
`timescale 1ns/1ps
`include "eee_wake_consts.svh"

module eee_capability_wake_error
    import eee_wake_pkg::*;
#(
    parameter logic [3:0] PORT_NUM = 4'h1
)
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        thresh_load,
    input  wire logic [15:0] thresh_value,
    input  wire logic        hw_neg_en,
    input  wire logic        np_done,
    input  wire logic [5:0]  np_partner_caps,
    input  wire logic        lpi_pin,
    input  wire logic        idle_pin,
    output logic             local_adv_100tx
);

    logic [7:0]    ind_ctrl_q;
    logic [7:0]    ind_offset_q;
    partner_caps_t partner_caps_q;
    logic [15:0]   thresh_q;
    logic [15:0]   err_cnt_q;
    logic [15:0]   err_cnt_d;
    logic [7:0]    err_lo_snap_q;
    logic [7:0]    rdata_d;
    logic          wake_err;
    logic          sel_hit;
    logic          data_wr;
    logic          data_rd;
    logic          err_hi_rd;

    // Assemble the capability word; reserved positions stay zero.
    function automatic logic [15:0] cap_word(input partner_caps_t caps, input logic local_adv);
        logic [15:0] w;
        w                           = 16'h0000;  // [R15]
        w[`CAP_PARTNER_10GKR_BIT]   = caps[5];   // [R1]
        w[`CAP_PARTNER_10GKX4_BIT]  = caps[4];   // [R2]
        w[`CAP_PARTNER_1GKX_BIT]    = caps[3];   // [R3]
        w[`CAP_PARTNER_10GT_BIT]    = caps[2];   // [R4]
        w[`CAP_PARTNER_1GT_BIT]     = caps[1];   // [R5]
        w[`CAP_PARTNER_100TX_BIT]   = caps[0];   // [R6]
        w[`CAP_LOCAL_BIT]           = local_adv; // [R7]
        cap_word = w;
    endfunction

    // The window only opens onto this port when the EEE space and our port number match.
    assign sel_hit = (ind_ctrl_q[`IND_SPACE_HI:`IND_SPACE_LO] == `IND_SPACE_EEE) && // [R11]
                     (ind_ctrl_q[`IND_PORT_HI:`IND_PORT_LO] == PORT_NUM);
    assign data_wr   = reg_wr && (reg_addr == `IND_DATA_ADDR) && sel_hit; // [R12]
    assign data_rd   = reg_rd && (reg_addr == `IND_DATA_ADDR) && sel_hit; // [R12]
    assign err_hi_rd = data_rd && (ind_offset_q == `ERR_HI_OFF);

    // Window selector and offset registers.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ind_ctrl_q   <= `IND_CTRL_RESET;
            ind_offset_q <= `IND_OFFSET_RESET;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == `IND_CTRL_ADDR) begin
                ind_ctrl_q <= reg_wdata; // [R11]
            end
            if (reg_addr == `IND_OFFSET_ADDR) begin
                ind_offset_q <= reg_wdata; // [R12]
            end
        end
    end

    // Partner flags change only by the hardware next-page exchange, never by software.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            partner_caps_q <= `PARTNER_CAPS_RESET; // [R6]
        end else if (clk_en && hw_neg_en && np_done) begin
            partner_caps_q <= np_partner_caps; // [R14]
        end
    end

    // Local advertisement; only bit 1 of the low capability byte is writable.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            local_adv_100tx <= `LOCAL_ADV_RESET; // [R7]
        end else if (clk_en && data_wr && ind_offset_q == `CAP_LO_OFF) begin
            local_adv_100tx <= reg_wdata[`CAP_LOCAL_BIT]; // [R7] [R15]
        end
    end

    // Threshold copy of the global setting, loaded whenever the global register is written.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            thresh_q <= `WAKE_THRESH_CYC; // [R9]
        end else if (clk_en && thresh_load) begin
            thresh_q <= thresh_value; // [R9]
        end
    end

    wake_timer u_wake_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .lpi_pin  (lpi_pin),
        .idle_pin (idle_pin),
        .thresh   (thresh_q),
        .wake_err (wake_err)
    );

    // Read-clear counter; an error in the clearing cycle survives as a count of one.
    always_comb begin
        if (err_hi_rd) begin
            err_cnt_d = wake_err ? 16'h0001 : `ERR_CNT_RESET; // [R10]
        end else if (wake_err) begin
            err_cnt_d = sat_inc16(err_cnt_q); // [R8] [R16]
        end else begin
            err_cnt_d = err_cnt_q;
        end
    end

    // Reading the high byte clears the counter and parks the low byte for the next read,
    // so the two bytes always belong to the same sample.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_cnt_q     <= `ERR_CNT_RESET; // [R10]
            err_lo_snap_q <= 8'h00;
        end else if (clk_en) begin
            err_cnt_q <= err_cnt_d;
            if (err_hi_rd) begin
                err_lo_snap_q <= err_cnt_q[7:0]; // [R13]
            end
        end
    end

    // Read data mux; unmatched addresses and offsets answer zero.
    always_comb begin
        logic [15:0] cw;
        cw      = cap_word(partner_caps_q, local_adv_100tx);
        rdata_d = 8'h00;
        if (reg_addr == `IND_CTRL_ADDR) begin
            rdata_d = ind_ctrl_q;
        end else if (reg_addr == `IND_OFFSET_ADDR) begin
            rdata_d = ind_offset_q;
        end else if (data_rd) begin
            case (ind_offset_q)
                `CAP_HI_OFF: rdata_d = cw[15:8];
                `CAP_LO_OFF: rdata_d = cw[7:0];
                `ERR_HI_OFF: rdata_d = err_cnt_q[15:8]; // [R13]
                `ERR_LO_OFF: rdata_d = err_lo_snap_q;   // [R13]
                default:     rdata_d = 8'h00;
            endcase
        end
    end

    // Read data is held until the next read.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (clk_en && reg_rd) begin
            reg_rdata <= rdata_d;
        end
    end

    sequence s_hi_read;
        clk_en && err_hi_rd;
    endsequence

    sequence s_cap_lo_read;
        clk_en && data_rd && ind_offset_q == `CAP_LO_OFF;
    endsequence

    property p_rc_clear;
        @(posedge core_clk) disable iff (!rst_n)
        s_hi_read ##0 !wake_err |=> err_cnt_q == 16'h0000 && reg_rdata == $past(err_cnt_q[15:8]);
    endproperty
    a_rc_clear: assert property (p_rc_clear) else $error("Counter not read then cleared."); // [R10]

    property p_snap_pair;
        @(posedge core_clk) disable iff (!rst_n)
        s_hi_read |=> err_lo_snap_q == $past(err_cnt_q[7:0]);
    endproperty
    a_snap_pair: assert property (p_snap_pair) else $error("Low byte not captured."); // [R13]

    property p_inc;
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && wake_err && !err_hi_rd && err_cnt_q != 16'hffff
            |=> err_cnt_q == 16'($past(err_cnt_q) + 16'h0001);
    endproperty
    a_inc: assert property (p_inc) else $error("Wake error not counted."); // [R8]

    property p_saturate;
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && err_cnt_q == 16'hffff && !err_hi_rd |=> err_cnt_q == 16'hffff;
    endproperty
    a_saturate: assert property (p_saturate) else $error("Counter wrapped."); // [R16]

    property p_cap_lo;
        @(posedge core_clk) disable iff (!rst_n)
        s_cap_lo_read |=> reg_rdata == {6'h00, $past(local_adv_100tx), 1'b0};
    endproperty
    a_cap_lo: assert property (p_cap_lo) else $error("Low capability byte wrong."); // [R15]

    property p_cap_hi;
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && data_rd && ind_offset_q == `CAP_HI_OFF
            |=> reg_rdata == {1'b0, $past(partner_caps_q), 1'b0};
    endproperty
    a_cap_hi: assert property (p_cap_hi) else $error("Partner flags misplaced."); // [R1]

    property p_np_load;
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && hw_neg_en && np_done |=> partner_caps_q == $past(np_partner_caps);
    endproperty
    a_np_load: assert property (p_np_load) else $error("Partner flags not loaded."); // [R14]

    property p_caps_ro;
        @(posedge core_clk) disable iff (!rst_n)
        !(hw_neg_en && np_done) |=> $stable(partner_caps_q);
    endproperty
    a_caps_ro: assert property (p_caps_ro) else $error("Partner flags changed."); // [R6]

    property p_local_hold;
        @(posedge core_clk) disable iff (!rst_n)
        !(data_wr && ind_offset_q == `CAP_LO_OFF) |=> $stable(local_adv_100tx);
    endproperty
    a_local_hold: assert property (p_local_hold) else $error("Local bit changed."); // [R7]

endmodule

// *** eee_wake_consts.svh ***
// Offsets, field positions, reset values and timing counts for the EEE port register block.
`ifndef EEE_WAKE_CONSTS_SVH
`define EEE_WAKE_CONSTS_SVH

// Direct registers of the indirect access window.
`define IND_CTRL_ADDR     8'h6e
`define IND_OFFSET_ADDR   8'h6f
`define IND_DATA_ADDR     8'ha0

// Fields of the indirect control register.
`define IND_SPACE_HI      7
`define IND_SPACE_LO      5
`define IND_PORT_HI       3
`define IND_PORT_LO       0
`define IND_SPACE_EEE     3'h1
`define IND_CTRL_RESET    8'h00
`define IND_OFFSET_RESET  8'h00

// Indirect byte offsets inside the EEE space.
`define CAP_HI_OFF        8'h28
`define CAP_LO_OFF        8'h29
`define ERR_HI_OFF        8'h2a
`define ERR_LO_OFF        8'h2b

// Bit positions of the capability register.
`define CAP_PARTNER_10GKR_BIT  14
`define CAP_PARTNER_10GKX4_BIT 13
`define CAP_PARTNER_1GKX_BIT   12
`define CAP_PARTNER_10GT_BIT   11
`define CAP_PARTNER_1GT_BIT    10
`define CAP_PARTNER_100TX_BIT  9
`define CAP_LOCAL_BIT          1

// Reset values and the counter maximum.
`define PARTNER_CAPS_RESET 6'h00
`define LOCAL_ADV_RESET    1'b1
`define ERR_CNT_RESET      16'h0000
`define ERR_CNT_MAX        16'hffff

// Timing: core clock rate and the default wake-up error threshold.
`define CORE_CLK_KHZ      10000
`define WAKE_THRESH_NS    20500
`define WAKE_THRESH_CYC   16'((`WAKE_THRESH_NS * `CORE_CLK_KHZ) / 1000000)

`endif

// *** eee_wake_pkg.sv ***
// Types and shared helpers for the EEE port register block.
package eee_wake_pkg;

    // Phases of one low power idle episode as seen by the wake timer.
    typedef enum logic [1:0] {
        WS_AWAKE,
        WS_LPI,
        WS_WAKING,
        WS_LATE
    } wake_state_t;

    // Partner capability flags, bit 5 is 10GBASE-KR down to bit 0 for 100BASE-TX.
    typedef logic [5:0] partner_caps_t;

    // Sixteen-bit increment that sticks at all ones instead of wrapping.
    function automatic logic [15:0] sat_inc16(input logic [15:0] v);
        sat_inc16 = (v == 16'hffff) ? v : 16'(v + 16'h0001);
    endfunction

endpackage

// *** link_partner_model.sv ***
// Behavioural link partner: low power idle episodes and next-page capability results.
`timescale 1ns/1ps

module link_partner_model (
    input  wire logic       core_clk,
    output logic            lpi_pin,
    output logic            idle_pin,
    output logic            np_done,
    output logic [5:0]      np_partner_caps
);

    // The line starts in normal idle; the caps lines carry junk outside the done cycle.
    initial begin
        lpi_pin = 1'b0;
        idle_pin = 1'b1;
        np_done = 1'b0;
        np_partner_caps = 6'h2a;
    end

    // One episode: quiet for lpi_len cycles, then a wake of wake_len cycles until idle returns.
    task automatic episode(input int lpi_len, input int wake_len);
        @(posedge core_clk);
        lpi_pin <= 1'b1;
        idle_pin <= 1'b0;
        repeat (lpi_len) @(posedge core_clk);
        lpi_pin <= 1'b0;
        repeat (wake_len) @(posedge core_clk);
        idle_pin <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask

    // A finished next-page exchange; the result is valid in the done cycle only.
    task automatic exchange(input logic [5:0] caps);
        @(posedge core_clk);
        np_done <= 1'b1;
        np_partner_caps <= caps;
        @(posedge core_clk);
        np_done <= 1'b0;
        np_partner_caps <= ~caps; // A late latch would pick up the inverse.
    endtask

endmodule

// *** test_eee_capability_wake_error.sv ***
// Self-checking bench for the EEE capability flags and wake-up error counter.
`timescale 1ns/1ps
`include "eee_wake_consts.svh"

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end

module test_eee_capability_wake_error;
    logic        core_clk, rst_n, clk_en, reg_wr, reg_rd, thresh_load, hw_neg_en;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_val, wval;
    logic [15:0] thresh_value;
    logic        lpi_pin, idle_pin, np_done, local_adv_100tx;
    logic [5:0]  np_partner_caps, caps;
    logic [31:0] seed, rnd;
    logic        adv_exp;
    int          num_errors, n_tests, cnt_exp;

    eee_capability_wake_error #(.PORT_NUM(4'h2)) u_eee_capability_wake_error (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .thresh_load(thresh_load), .thresh_value(thresh_value), .hw_neg_en(hw_neg_en),
        .np_done(np_done), .np_partner_caps(np_partner_caps), .lpi_pin(lpi_pin),
        .idle_pin(idle_pin), .local_adv_100tx(local_adv_100tx));

    link_partner_model u_link_partner_model (
        .core_clk(core_clk), .lpi_pin(lpi_pin), .idle_pin(idle_pin),
        .np_done(np_done), .np_partner_caps(np_partner_caps));

    // Free-running 10 MHz core clock.
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Repeatable pseudo-random source.
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected capability bytes: partner flags sit at bits 14:9, local flag at bit 1.
    function automatic logic [7:0] cap_hi(input logic [5:0] c);
        return {1'b0, c, 1'b0};
    endfunction
    function automatic logic [7:0] cap_lo(input logic a);
        return {6'h00, a, 1'b0};
    endfunction

    // One direct write, strobe held for a single taken edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Indirect read: set the offset, then read the data byte 1 ns after the taking edge.
    task automatic rd(input logic [7:0] off, output logic [7:0] v);
        wr(`IND_OFFSET_ADDR, off);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= `IND_DATA_ADDR;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Indirect write of one byte.
    task automatic wri(input logic [7:0] off, input logic [7:0] d);
        wr(`IND_OFFSET_ADDR, off);
        wr(`IND_DATA_ADDR, d);
    endtask

    task automatic conclude();
        if (num_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run of about a thousand cycles.
    initial begin
        repeat (30000) @(posedge core_clk);
        num_errors++;
        conclude();
    end

    // Main sequence.
    initial begin
        seed = 32'd36;
        num_errors = 0;
        n_tests = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        thresh_load = 1'b0;
        thresh_value = 16'h0000;
        hw_neg_en = 1'b1;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        // Reset values of both capability bytes and the counter.
        wr(`IND_CTRL_ADDR, 8'h22);
        rd(`CAP_HI_OFF, rd_val);
        `CHK(rd_val, 8'h00)
        rd(`CAP_LO_OFF, rd_val);
        `CHK(rd_val, cap_lo(1'b1))
        `CHK(local_adv_100tx, 1'b1)
        rd(`ERR_HI_OFF, rd_val);
        `CHK(rd_val, 8'h00)
        // Random partner capability sets, each flag position seen high and low.
        for (int i = 0; i < 8; i++) begin
            rnd = xs();
            caps = (i < 6) ? 6'(6'h01 << i) : rnd[5:0];
            u_link_partner_model.exchange(caps);
            wri(`CAP_HI_OFF, 8'hff);
            rd(`CAP_HI_OFF, rd_val);
            `CHK(rd_val, cap_hi(caps))
        end
        // With hardware exchange off the flags hold.
        @(posedge core_clk);
        hw_neg_en <= 1'b0;
        u_link_partner_model.exchange(~caps);
        rd(`CAP_HI_OFF, rd_val);
        `CHK(rd_val, cap_hi(caps))
        // Random writes to the low byte keep only the local advertisement bit.
        for (int i = 0; i < 6; i++) begin
            rnd = xs();
            wval = (i == 0) ? 8'hfd : rnd[7:0];
            adv_exp = wval[1];
            wri(`CAP_LO_OFF, wval);
            rd(`CAP_LO_OFF, rd_val);
            `CHK(rd_val, cap_lo(adv_exp))
            `CHK(local_adv_100tx, adv_exp)
        end
        // Wrong port: a write is ignored and reads give zero; wrong space: reads give zero.
        wr(`IND_CTRL_ADDR, 8'h21);
        wri(`CAP_LO_OFF, {6'h00, ~adv_exp, 1'b0});
        rd(`CAP_LO_OFF, rd_val);
        `CHK(rd_val, 8'h00)
        wr(`IND_CTRL_ADDR, 8'h42);
        rd(`CAP_HI_OFF, rd_val);
        `CHK(rd_val, 8'h00)
        `CHK(local_adv_100tx, adv_exp)
        // A write while the clock enable is low has no effect.
        wr(`IND_CTRL_ADDR, 8'h22);
        clk_en <= 1'b0;
        wri(`CAP_LO_OFF, {6'h00, ~adv_exp, 1'b0});
        clk_en <= 1'b1;
        `CHK(local_adv_100tx, adv_exp)
        // Default threshold of 205 cycles: a short wake passes, a long one counts.
        u_link_partner_model.episode(30, 180);
        u_link_partner_model.episode(30, 240);
        rd(`ERR_HI_OFF, rd_val);
        `CHK(rd_val, 8'h00)
        rd(`ERR_LO_OFF, rd_val);
        `CHK(rd_val, 8'h01)
        // Lower the global threshold, then random short and long wakes.
        @(posedge core_clk);
        thresh_load <= 1'b1;
        thresh_value <= 16'h0014;
        @(posedge core_clk);
        thresh_load <= 1'b0;
        cnt_exp = 0;
        for (int i = 0; i < 8; i++) begin
            rnd = xs();
            if (rnd[0] || i == 0) begin
                u_link_partner_model.episode(10, 40);
                cnt_exp++;
            end else begin
                u_link_partner_model.episode(10, 8);
            end
        end
        rd(`ERR_HI_OFF, rd_val);
        `CHK(rd_val, 8'h00)
        rd(`ERR_LO_OFF, rd_val);
        `CHK(rd_val, 8'(cnt_exp))
        // The high-byte read cleared the count.
        rd(`ERR_HI_OFF, rd_val);
        `CHK(rd_val, 8'h00)
        rd(`ERR_LO_OFF, rd_val);
        `CHK(rd_val, 8'h00)
        conclude();
    end
endmodule

// *** wake_timer.sv ***
// Times each wake-up from low power idle and flags those that exceed the threshold.
`timescale 1ns/1ps
`include "eee_wake_consts.svh"

module wake_timer
    import eee_wake_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        lpi_pin,
    input  wire logic        idle_pin,
    input  wire logic [15:0] thresh,
    output logic             wake_err
);

    logic [1:0]  lpi_sync_q;
    logic [1:0]  idle_sync_q;
    wake_state_t state_q;
    logic [15:0] wake_cnt_q;

    // Both status lines come from the PHY domain, so each passes two flops first.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lpi_sync_q  <= 2'h0;
            idle_sync_q <= 2'h0;
        end else if (clk_en) begin
            lpi_sync_q  <= {lpi_sync_q[0], lpi_pin};
            idle_sync_q <= {idle_sync_q[0], idle_pin};
        end
    end

    // Episode sequencer; the counter starts when the partner leaves low power idle.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= WS_AWAKE;
            wake_cnt_q <= 16'h0000;
            wake_err   <= 1'b0;
        end else if (clk_en) begin
            wake_err <= 1'b0;
            case (state_q)
                WS_AWAKE: begin
                    if (lpi_sync_q[1]) begin
                        state_q <= WS_LPI;
                    end
                end
                WS_LPI: begin
                    wake_cnt_q <= 16'h0000;
                    if (!lpi_sync_q[1]) begin
                        state_q <= WS_WAKING;
                    end
                end
                WS_WAKING: begin
                    wake_cnt_q <= sat_inc16(wake_cnt_q);
                    if (idle_sync_q[1]) begin
                        state_q <= WS_AWAKE;
                    end else if (wake_cnt_q >= thresh) begin
                        // Reported once per episode, however long the wake drags on.
                        wake_err <= 1'b1; // [R8]
                        state_q  <= WS_LATE;
                    end
                end
                WS_LATE: begin
                    if (idle_sync_q[1]) begin
                        state_q <= WS_AWAKE;
                    end
                end
                default: begin
                    state_q <= WS_AWAKE;
                end
            endcase
        end
    end

    // An error pulse lasts one cycle and only ever follows a late wake.
    property p_err_single;
        @(posedge core_clk) disable iff (!rst_n)
        wake_err |-> $past(state_q) == WS_WAKING && state_q == WS_LATE;
    endproperty
    a_err_single: assert property (p_err_single) else $error("Wake error without a late wake."); // [R8]

    // A wake that reaches normal idle in time is never reported.
    property p_on_time;
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && state_q == WS_WAKING && idle_sync_q[1] |=> !wake_err;
    endproperty
    a_on_time: assert property (p_on_time) else $error("Timely wake was reported."); // [R8]

endmodule
